// ### peic_mgmt_model.sv
// Purpose: management controller issuing register accesses
// Assumes: one-cycle rd or wr pulse, answer one cycle after a read
// Notes: released fields carry inverted values so stale data shows
module peic_mgmt_model (
    input wire logic clk_i, // clock
    input wire logic [15:0] rdata_i, // read data
    input wire logic rvalid_i, // read valid
    output peic_pkg::peic_mgmt_req_type mgmt_o // access
);
    timeunit 1ns;
    timeprecision 100ps;
    initial mgmt_o = '0;
    // one access; read data is taken at the answering edge
    task automatic access(input logic w, input logic [4:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        #2 mgmt_o = {~w, w, a, d};
        @(posedge clk_i);
        #2 mgmt_o = {2'b00, ~a, ~d};
        q = 16'h0000;
        if (!w) begin
            @(posedge clk_i);
            q = rvalid_i ? rdata_i : 16'hxxxx;
            #2;
        end
    endtask
endmodule

// ### peic_pkg.sv
// Purpose: shared constants and types for the port event and counter block
// Assumes: 5-bit management register address, 16-bit register data
// Notes: offsets are register indices on the management interface
package peic_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [4:0] ADDR_IRQ_CTRL = 5'h11;
    localparam logic [4:0] ADDR_EVT_STAT_EN = 5'h12;
    localparam logic [4:0] ADDR_PAGE_SEL = 5'h13;
    localparam logic [4:0] ADDR_FC_COUNT = 5'h14;
    localparam logic [4:0] ADDR_RX_ERR_COUNT = 5'h15;
    localparam logic [4:0] ADDR_PAGED_LO = 5'h14;
    localparam logic [1:0] PAGE_EXT0 = 2'h0;
    localparam logic [1:0] PAGE_DIAG = 2'h2;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int EVT_COUNT = 8;
    localparam int STAT_LSB = 8;
    localparam int EN_LSB = 0;
    localparam int CTRL_OE_BIT = 0;
    localparam int CTRL_GIE_BIT = 1;
    localparam int CTRL_TEST_BIT = 2;
    localparam int CNT_WIDTH = 8;
    // event bit order inside the 8-bit event vector (7 = bit 15)
    localparam int EV_LINK_QUALITY = 7;
    localparam int EV_ENERGY = 6;
    localparam int EV_LINK = 5;
    localparam int EV_SPEED = 4;
    localparam int EV_DUPLEX = 3;
    localparam int EV_AUTONEG = 2;
    localparam int EV_FC_HALF = 1;
    localparam int EV_RX_ERR_HALF = 0;

    // management access from the serial interface front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } peic_mgmt_req_type;

    // receive-side qualifiers for the error counters
    typedef struct packed {
        logic false_carrier;
        logic carrier;
        logic symbol_error;
        logic collision;
    } peic_rx_evt_type;
endpackage

// ### peic_sat_counter.sv
// Purpose: saturating event counter that clears on read
// Assumes: increment and clear come from logic on the same clock
// Notes: raises a one-cycle half pulse when the msb first becomes set
module peic_sat_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,           // system clock
    input wire logic rst_n_i,         // async reset, active low
    input wire logic inc_i,           // count one event
    input wire logic clr_i,           // read clear
    output logic [WIDTH-1:0] count_o, // present count
    output logic half_o               // msb became set
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic half_reg;

    // saturate at all ones, read clears, an event in the read cycle counts
    always_comb begin
        count_next = count_reg;
        if (clr_i) begin
            count_next = '0;
        end
        // a clear frees a saturated counter, so the same-cycle event counts
        if (inc_i && (clr_i || (count_reg != {WIDTH{1'b1}}))) begin
            count_next = clr_i ? WIDTH'(1) : count_reg + WIDTH'(1);
        end
    end

    // count register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // half-full event on the msb rising
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= count_next[WIDTH-1] && !count_reg[WIDTH-1];
        end
    end

    assign count_o = count_reg;
    assign half_o = half_reg;
endmodule

// ### peic_top.sv
// Purpose: event status, irq control, page select and error counters
// Assumes: event inputs are one-cycle pulses from same-clock logic
// Notes: powerdown pin is a tri-state style triple, enable high drives
//
// Overview of operation
// - status bit sets on event and stays set until status register read
// - irq requested for enabled pending event when global controls allow
// - status bits capture events whatever the enable bits say
// - bits 15..10: link quality, energy, link, speed, duplex, autoneg
// - bit 9 false carrier half full, bit 8 rx error half full
// - bits 7..0 read-write enables, reset 0, same order as status
// - page field bits 1:0 selects bank at 14h..1Fh; 0 ext, 2 diag
// - reserved page and counter bits ignore writes and read zero
// - 8-bit false carrier counter, saturates at FFh, clears on read
// - rx error counter counts once per carrier with bad symbols
// - no rx error count for a carrier event with collision
// - rx error counter saturates and clears when read
// - event interrupts delivered only while global enable bit 1 set
// - pin drives interrupt only while output enable bit 0 set
// - test bit 2 keeps an interrupt generated regardless of events
module peic_top (
    input wire logic clk_i,                      // 40 MHz port clock
    input wire logic rst_n_i,                    // async reset, active low
    input peic_pkg::peic_mgmt_req_type mgmt_i,   // management access
    input wire logic [5:0] phy_evt_i,            // link..autoneg pulses
    input peic_pkg::peic_rx_evt_type rx_evt_i,   // receive qualifiers
    input wire logic pin_i,                      // powerdown pin level
    output logic [15:0] rdata_o,                 // read data, one cycle on
    output logic rvalid_o,                       // read data valid pulse
    output logic [1:0] page_o,                   // active paged bank
    output logic paged_diag_o,                   // diag page answers now
    output logic irq_pin_o,                      // pin level, active low
    output logic irq_pin_oe_o,                   // pin output enable
    output logic powerdown_o                     // pin used as power down
);
    logic [peic_pkg::EVT_COUNT-1:0] pending_reg;
    logic [peic_pkg::EVT_COUNT-1:0] enable_reg;
    logic [2:0] ctrl_reg;
    logic [1:0] page_reg;
    logic diag_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic irq_pin_reg;
    logic irq_oe_reg;
    logic pd_reg;
    logic pin_sync1_reg;
    logic pin_sync2_reg;
    logic in_carrier_reg;
    logic carrier_bad_reg;
    logic carrier_col_reg;
    logic carrier_counted_reg;
    logic [peic_pkg::EVT_COUNT-1:0] evt_vec;
    logic [peic_pkg::CNT_WIDTH-1:0] fc_count;
    logic [peic_pkg::CNT_WIDTH-1:0] rx_count;
    logic fc_half;
    logic rx_half;
    logic rd_stat;
    logic rd_fc;
    logic rd_rx;
    logic wr_stat;
    logic wr_page;
    logic wr_ctrl;
    logic ext_page;
    logic rx_inc;
    logic irq_req;

    // ************************************************************
    // address decode
    // ************************************************************
    // counters sit on the paged window, only visible on page 0
    assign ext_page = (page_reg == peic_pkg::PAGE_EXT0);
    assign rd_stat = mgmt_i.rd && (mgmt_i.addr == peic_pkg::ADDR_EVT_STAT_EN);
    assign rd_fc = mgmt_i.rd && ext_page &&
                   (mgmt_i.addr == peic_pkg::ADDR_FC_COUNT);
    assign rd_rx = mgmt_i.rd && ext_page &&
                   (mgmt_i.addr == peic_pkg::ADDR_RX_ERR_COUNT);
    assign wr_stat = mgmt_i.wr && (mgmt_i.addr == peic_pkg::ADDR_EVT_STAT_EN);
    assign wr_page = mgmt_i.wr && (mgmt_i.addr == peic_pkg::ADDR_PAGE_SEL);
    assign wr_ctrl = mgmt_i.wr && (mgmt_i.addr == peic_pkg::ADDR_IRQ_CTRL);

    // ************************************************************
    // receive error qualification
    // ************************************************************
    // track one carrier event; count at its end if bad and collision free
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_carrier_reg <= 1'b0;
            carrier_bad_reg <= 1'b0;
            carrier_col_reg <= 1'b0;
            carrier_counted_reg <= 1'b0;
        end else begin
            in_carrier_reg <= rx_evt_i.carrier;
            if (rx_evt_i.carrier && !in_carrier_reg) begin
                carrier_bad_reg <= rx_evt_i.symbol_error;
                carrier_col_reg <= rx_evt_i.collision;
                carrier_counted_reg <= 1'b0;
            end else if (rx_evt_i.carrier) begin
                carrier_bad_reg <= carrier_bad_reg || rx_evt_i.symbol_error;
                carrier_col_reg <= carrier_col_reg || rx_evt_i.collision;
            end
            if (rx_inc) begin
                carrier_counted_reg <= 1'b1;
            end
        end
    end

    // count once when the carrier ends with errors and no collision
    assign rx_inc = in_carrier_reg && !rx_evt_i.carrier &&
                    carrier_bad_reg && !carrier_col_reg &&
                    !carrier_counted_reg;

    // ************************************************************
    // error counters
    // ************************************************************
    peic_sat_counter #(
        .WIDTH(peic_pkg::CNT_WIDTH)
    ) u_fc_count (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(rx_evt_i.false_carrier),
        .clr_i(rd_fc),
        .count_o(fc_count),
        .half_o(fc_half)
    );

    peic_sat_counter #(
        .WIDTH(peic_pkg::CNT_WIDTH)
    ) u_rx_count (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(rx_inc),
        .clr_i(rd_rx),
        .count_o(rx_count),
        .half_o(rx_half)
    );

    // ************************************************************
    // event status and enables
    // ************************************************************
    // event vector in status bit order, bit 7 maps to register bit 15
    assign evt_vec = {phy_evt_i, fc_half, rx_half};

    // sticky capture independent of enables; a new event beats the read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= (rd_stat ? '0 : pending_reg) |
                           evt_vec;
        end
    end

    // read-write enable bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_reg <= '0;
        end else if (wr_stat) begin
            enable_reg <= mgmt_i.wdata[peic_pkg::EN_LSB +: 8];
        end
    end

    // ************************************************************
    // control and page select
    // ************************************************************
    // reserved upper bits are dropped on write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_reg <= '0;
            diag_reg <= 1'b0;
        end else if (wr_page) begin
            page_reg <= mgmt_i.wdata[1:0];
            diag_reg <= (mgmt_i.wdata[1:0] == peic_pkg::PAGE_DIAG);
        end
    end

    // interrupt control bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= '0;
        end else if (wr_ctrl) begin
            ctrl_reg <= mgmt_i.wdata[2:0];
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // registered read mux; unmapped or other-page addresses read zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= peic_pkg::REG_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= mgmt_i.rd;
            rdata_reg <= peic_pkg::REG_RESET;
            if (mgmt_i.rd) begin
                if (mgmt_i.addr == peic_pkg::ADDR_IRQ_CTRL) begin
                    rdata_reg <= {13'h0000, ctrl_reg};
                end else if (rd_stat) begin
                    rdata_reg <= {pending_reg, enable_reg};
                end else if (mgmt_i.addr == peic_pkg::ADDR_PAGE_SEL) begin
                    rdata_reg <= {14'h0000, page_reg};
                end else if (rd_fc) begin
                    rdata_reg <= {8'h00, fc_count};
                end else if (rd_rx) begin
                    rdata_reg <= {8'h00, rx_count};
                end
            end
        end
    end

    // ************************************************************
    // interrupt pin
    // ************************************************************
    // event request gated by global enable, test bit forces a request
    assign irq_req = (ctrl_reg[peic_pkg::CTRL_GIE_BIT] &&
                      |(pending_reg & enable_reg)) ||
                     ctrl_reg[peic_pkg::CTRL_TEST_BIT];

    // pin input synchroniser for power-down use
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync1_reg <= 1'b1;
            pin_sync2_reg <= 1'b1;
        end else begin
            pin_sync1_reg <= pin_i;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // pin drives low on interrupt only when configured as output
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_oe_reg <= 1'b0;
            irq_pin_reg <= 1'b1;
            pd_reg <= 1'b0;
        end else begin
            irq_oe_reg <= ctrl_reg[peic_pkg::CTRL_OE_BIT];
            irq_pin_reg <= !irq_req;
            pd_reg <= !ctrl_reg[peic_pkg::CTRL_OE_BIT] &&
                      !pin_sync2_reg;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign page_o = page_reg;
    assign paged_diag_o = diag_reg;
    assign irq_pin_o = irq_pin_reg;
    assign irq_pin_oe_o = irq_oe_reg;
    assign powerdown_o = pd_reg;
endmodule

// ### peic_top_assertions.sv
// Purpose: port-level checks for the event and counter block
// Assumes: one clock, async active-low reset
// Notes: bound to peic_top after the module
module peic_top_chk (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input peic_pkg::peic_mgmt_req_type mgmt_i, // management access
    input wire logic [15:0] rdata_o, // read data
    input wire logic rvalid_o, // read valid
    input wire logic [1:0] page_o, // active page
    input wire logic paged_diag_o, // diag page flag
    input wire logic irq_pin_o, // pin level
    input wire logic irq_pin_oe_o, // pin enable
    input wire logic powerdown_o // power down use
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // every read answers one cycle later
    AST_RD_ANSWER: assert property (mgmt_i.rd |=> rvalid_o)
        else $error("read not answered");
    // no answer and zero data without a read
    AST_NO_SPURIOUS: assert property (!mgmt_i.rd |=> !rvalid_o &&
        rdata_o == 16'h0000) else $error("spurious read data");
    AST_PAGE_RSVD: assert property (
        mgmt_i.rd && mgmt_i.addr == peic_pkg::ADDR_PAGE_SEL
        |=> rdata_o[15:2] == 14'h0000) else $error("page reserved set");
    AST_CNT_RSVD: assert property (
        mgmt_i.rd && (mgmt_i.addr == peic_pkg::ADDR_FC_COUNT ||
        mgmt_i.addr == peic_pkg::ADDR_RX_ERR_COUNT)
        |=> rdata_o[15:8] == 8'h00) else $error("count reserved set");
    AST_HIDDEN: assert property (
        mgmt_i.rd && mgmt_i.addr == peic_pkg::ADDR_FC_COUNT &&
        page_o != peic_pkg::PAGE_EXT0 |=> rdata_o == 16'h0000)
        else $error("counter visible off page 0");
    AST_UNMAPPED: assert property (mgmt_i.rd && mgmt_i.addr == 5'h00
        |=> rdata_o == 16'h0000) else $error("unmapped read nonzero");
    AST_DIAG: assert property (
        paged_diag_o == (page_o == peic_pkg::PAGE_DIAG))
        else $error("diag flag wrong");
    AST_PAGE_WR: assert property (
        mgmt_i.wr && mgmt_i.addr == peic_pkg::ADDR_PAGE_SEL
        |=> page_o == $past(mgmt_i.wdata[1:0])) else $error("page lost");
    AST_OE_ON: assert property (
        mgmt_i.wr && mgmt_i.addr == peic_pkg::ADDR_IRQ_CTRL &&
        mgmt_i.wdata[0] |-> ##[1:2] irq_pin_oe_o) else $error("oe low");
    AST_OE_OFF: assert property (
        mgmt_i.wr && mgmt_i.addr == peic_pkg::ADDR_IRQ_CTRL &&
        !mgmt_i.wdata[0] |-> ##[1:2] !irq_pin_oe_o) else $error("oe high");
    AST_TEST: assert property (
        mgmt_i.wr && mgmt_i.addr == peic_pkg::ADDR_IRQ_CTRL &&
        mgmt_i.wdata[2] |-> ##[1:3] !irq_pin_o) else $error("no test irq");
    AST_PIN_ROLE: assert property (
        irq_pin_oe_o && $past(irq_pin_oe_o) |-> !powerdown_o)
        else $error("pin both output and power down");
endmodule
bind peic_top peic_top_chk u_chk (.clk_i, .rst_n_i, .mgmt_i, .rdata_o,
    .rvalid_o, .page_o, .paged_diag_o, .irq_pin_o, .irq_pin_oe_o,
    .powerdown_o);

// ### phy_event_irq_and_error_counters_bench.sv
// Purpose: self-checking bench for the event and counter block
// Assumes: inputs change 2 ns after the rising edge
// Notes: register traffic goes through the management model
module phy_event_irq_and_error_counters_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    peic_pkg::peic_mgmt_req_type mgmt;
    logic [5:0] evt = 6'h00;
    peic_pkg::peic_rx_evt_type rx = '0;
    logic pin = 1'b1;
    logic [15:0] rdata;
    logic [1:0] page;
    logic rvalid, diag, irq, oe, pd;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    peic_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mgmt_i(mgmt),
        .phy_evt_i(evt), .rx_evt_i(rx), .pin_i(pin), .rdata_o(rdata),
        .rvalid_o(rvalid), .page_o(page), .paged_diag_o(diag),
        .irq_pin_o(irq), .irq_pin_oe_o(oe), .powerdown_o(pd));
    peic_mgmt_model u_mgmt (.clk_i(clk_i), .rdata_i(rdata),
        .rvalid_i(rvalid), .mgmt_o(mgmt));
    // 40 MHz clock and a hang limit
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        u_mgmt.access(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        u_mgmt.access(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask
    task automatic pulse(input logic [5:0] e);
        evt = e;
        tick(1);
        evt = 6'h00;
        tick(3);
    endtask
    // all six phy events latch with enables off; one read clears them
    task automatic t_status();
        pulse(6'h3f);
        chk({15'h0000, irq}, 16'h0001);
        rdc(5'h12, 16'hfc00);
        rdc(5'h12, 16'h0000);
    endtask
    // enabled link event drives the pin only with global enable
    task automatic t_irq();
        wr(5'h11, 16'h0003);
        wr(5'h12, 16'h0020);
        rdc(5'h12, 16'h0020);
        pulse(6'h08);
        chk({15'h0000, irq}, 16'h0000);
        chk({15'h0000, oe}, 16'h0001);
        rdc(5'h12, 16'h2020);
        tick(2);
        chk({15'h0000, irq}, 16'h0001);
        wr(5'h11, 16'h0001);
        pulse(6'h08);
        chk({15'h0000, irq}, 16'h0001);
        rdc(5'h12, 16'h2020);
    endtask
    // test interrupt, reserved control bits, pin as power down input
    task automatic t_test();
        wr(5'h11, 16'hfffc);
        rdc(5'h11, 16'h0004);
        pin = 1'b0;
        tick(4);
        chk({15'h0000, irq}, 16'h0000);
        chk({14'h0000, oe, pd}, 16'h0001);
        wr(5'h11, 16'h0000);
        pin = 1'b1;
        tick(4);
        chk({14'h0000, irq, pd}, 16'h0002);
    endtask
    // false carrier saturation, page hiding, half-full raised once
    task automatic t_fc();
        rx.false_carrier = 1'b1;
        tick(300);
        rx.false_carrier = 1'b0;
        wr(5'h13, 16'hfffe);
        rdc(5'h13, 16'h0002);
        chk({14'h0000, page}, 16'h0002);
        chk({15'h0000, diag}, 16'h0001);
        rdc(5'h14, 16'h0000);
        wr(5'h13, 16'h0000);
        wr(5'h14, 16'hffff);
        rdc(5'h14, 16'h00ff);
        rdc(5'h14, 16'h0000);
        rdc(5'h12, 16'h0220);
        rdc(5'h12, 16'h0020);
    endtask
    task automatic carrier(input logic se, input logic col);
        rx = {1'b0, 1'b1, se, col};
        tick(2);
        rx = '0;
        tick(1);
    endtask
    // one count per bad carrier, none with collision, saturation
    task automatic t_rx();
        carrier(1'b1, 1'b0);
        carrier(1'b1, 1'b1);
        carrier(1'b0, 1'b0);
        rdc(5'h15, 16'h0001);
        repeat (260) carrier(1'b1, 1'b0);
        rdc(5'h15, 16'h00ff);
        rdc(5'h15, 16'h0000);
        rdc(5'h12, 16'h0120);
    endtask
    // reset, then every scenario in turn
    initial begin
        tick(10);
        rst_n_i = 1'b1;
        for (int a = 17; a <= 21; a++) begin
            rdc(a[4:0], 16'h0000);
        end
        rdc(5'h00, 16'h0000);
        t_status();
        t_irq();
        t_test();
        t_fc();
        t_rx();
        summarize();
    end
endmodule
